/* File: hw/coap_parser.sv */
// Cyclic output assembly parser with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Function
// - Full-control format accepted at any length from 1 to 262 bytes.
// - Entry-only format accepted at any length from 1 to 261 bytes.
// - Full format byte 0: activation, ack, data reset, error ack, standby.
// - Full format bytes 1-3 fragment fields; byte 4 new-entry and new-data flags.
// - Full format bytes 5-6 entry length low/high; data bytes 7 to 261.
// - Entry-only format: no control byte; bytes 0-2 fragments, byte 3 flags.
// - Entry-only bytes 4-5 entry length; data bytes 6 to 260.
// - Length fixed at configuration; any length within format limits accepted.
// - Toggle flags act only on transitions, never on steady level.
// - Activation rise opens reading gate, fall closes it.
// - Data acknowledgement honoured only in acknowledged handshake mode.
// - Data reset discards stored results and clears the input data area.
module coap_parser (
	// Clock, reset, enable
	input  wire logic        I_CLOCK,
	input  wire logic        I_RST_N,
	input  wire logic        I_CE,
	// Assembly byte stream
	input  wire logic        I_RX_VALID,
	input  wire logic [7:0]  I_RX_DATA,
	input  wire logic        I_RX_LAST,
	// Avalon-MM slave
	input  wire logic [3:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0]      O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	// Device controls
	output logic             O_GATE_OPEN,
	output logic             O_STANDBY,
	output logic             O_ACK_PULSE,
	output logic             O_DATA_RESET,
	output logic             O_ERROR_ACK,
	output logic             O_NEW_ENTRY,
	output logic             O_FRAME_DONE,
	// Entry data out
	output logic             O_ENTRY_VALID,
	output logic [7:0]       O_ENTRY_DATA,
	output logic [7:0]       O_ENTRY_INDEX
);
	import coap_pkg::*;
	// Configuration and status state
	logic        fmt_entry_reg, fmt_entry_next;
	logic        ack_mode_reg, ack_mode_next;
	logic [8:0]  len_reg, len_next;
	logic        err_reg, err_next;
	logic [8:0]  idx_reg, idx_next;
	logic [4:0]  ctl_prev_reg, ctl_prev_next;
	logic        ne_prev_reg, ne_prev_next;
	logic [7:0]  frag_num_reg, frag_num_next;
	logic [7:0]  frag_rem_reg, frag_rem_next;
	logic [7:0]  frag_size_reg, frag_size_next;
	logic [1:0]  flags_reg, flags_next;
	logic [15:0] entry_len_reg, entry_len_next;
	logic [7:0]  entry_cnt_reg, entry_cnt_next;
	// Output state
	logic        gate_reg, gate_next, stby_reg, stby_next;
	logic        ack_reg, ack_next, drst_reg, drst_next, eack_reg, eack_next;
	logic        newe_reg, newe_next, done_reg, done_next, ev_reg, ev_next;
	logic [7:0]  ed_reg, ed_next;
	logic [7:0]  ei_reg, ei_next;
	logic        wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	// Decode helpers
	logic        take, in_len, len_ok, err_set, ctl_take, bus_ack;
	logic [8:0]  max_len, pos;
	always_comb begin
		max_len  = fmt_entry_reg ? ENTRY_MAX_LEN : FULL_MAX_LEN;
		len_ok   = (len_reg != 9'h000) && (len_reg <= max_len);
		take     = I_CE && I_RX_VALID;
		in_len   = len_ok && (idx_reg < len_reg);
		// Entry-only bytes map one place up, onto the full layout
		pos      = fmt_entry_reg ? (idx_reg + 9'h001) : idx_reg;
		ctl_take = take && in_len && !fmt_entry_reg && (pos == POS_CTRL);
		err_set  = take && (!in_len || (I_RX_LAST && (idx_reg != len_reg - 9'h001)));
		bus_ack  = I_CE && (I_AVS_READ || I_AVS_WRITE) && !wait_reg;
	end
	// Stream parsing
	always_comb begin
		idx_next       = idx_reg;
		ctl_prev_next  = ctl_prev_reg;
		ne_prev_next   = ne_prev_reg;
		frag_num_next  = frag_num_reg;
		frag_rem_next  = frag_rem_reg;
		frag_size_next = frag_size_reg;
		flags_next     = flags_reg;
		entry_len_next = entry_len_reg;
		entry_cnt_next = entry_cnt_reg;
		gate_next      = gate_reg;
		stby_next      = stby_reg;
		ack_next       = 1'b0;
		drst_next      = 1'b0;
		eack_next      = 1'b0;
		newe_next      = 1'b0;
		done_next      = 1'b0;
		ev_next        = 1'b0;
		ed_next        = ed_reg;
		ei_next        = ei_reg;
		if (take) begin
			if (I_RX_LAST) begin
				idx_next  = 9'h000;
				done_next = 1'b1;
			end else if (idx_reg != 9'h1FF) begin
				idx_next = idx_reg + 9'h001;
			end
		end
		if (ctl_take) begin
			ctl_prev_next = I_RX_DATA[4:0];
			stby_next     = I_RX_DATA[CTL_STBY];
			if (I_RX_DATA[CTL_ACT] != ctl_prev_reg[CTL_ACT]) begin
				gate_next = I_RX_DATA[CTL_ACT];
			end
			ack_next  = ack_mode_reg && (I_RX_DATA[CTL_ACK] != ctl_prev_reg[CTL_ACK]);
			drst_next = I_RX_DATA[CTL_RST] && !ctl_prev_reg[CTL_RST];
			eack_next = I_RX_DATA[CTL_EACK] && !ctl_prev_reg[CTL_EACK];
		end
		if (take && in_len) begin
			unique case (1'b1)
				pos == POS_FRAG_NUM:  frag_num_next  = I_RX_DATA;
				pos == POS_FRAG_REM:  frag_rem_next  = I_RX_DATA;
				pos == POS_FRAG_SIZE: frag_size_next = I_RX_DATA;
				pos == POS_FLAGS: begin
					flags_next   = I_RX_DATA[1:0];
					ne_prev_next = I_RX_DATA[FLG_NEW_ENTRY];
					newe_next    = I_RX_DATA[FLG_NEW_ENTRY] != ne_prev_reg;
				end
				pos == POS_LEN_LO: entry_len_next[7:0]  = I_RX_DATA;
				pos == POS_LEN_HI: entry_len_next[15:8] = I_RX_DATA;
				pos >= POS_DATA: begin
					ev_next        = 1'b1;
					ed_next        = I_RX_DATA;
					ei_next        = 8'(pos - POS_DATA);
					entry_cnt_next = 8'(pos - POS_DATA + 9'h001);
				end
				default: ;
			endcase
		end
		if (drst_next) begin
			frag_num_next  = 8'h00;
			frag_rem_next  = 8'h00;
			frag_size_next = 8'h00;
			flags_next     = 2'h0;
			entry_len_next = 16'h0000;
			entry_cnt_next = 8'h00;
		end
	end
	// Register slave
	always_comb begin
		fmt_entry_next = fmt_entry_reg;
		ack_mode_next  = ack_mode_reg;
		len_next       = len_reg;
		err_next       = err_reg;
		rdata_next     = rdata_reg;
		wait_next      = wait_reg;
		if (I_CE) begin
			wait_next = !((I_AVS_READ || I_AVS_WRITE) && wait_reg);
		end
		if (I_CE && I_AVS_READ && wait_reg) begin
			unique case (I_AVS_ADDRESS)
				REG_CFG:   rdata_next = {15'h0000, len_reg, 6'h00, ack_mode_reg, fmt_entry_reg};
				REG_STAT:  rdata_next = {16'h0000, entry_cnt_reg, 5'h00, err_reg, stby_reg,
					gate_reg};
				REG_FRAG:  rdata_next = {6'h00, flags_reg, frag_size_reg, frag_rem_reg,
					frag_num_reg};
				REG_ENTRY: rdata_next = {16'h0000, entry_len_reg};
				default:   rdata_next = 32'h0000_0000;
			endcase
		end
		if (bus_ack && I_AVS_WRITE) begin
			if (I_AVS_ADDRESS == REG_CFG) begin
				fmt_entry_next = I_AVS_WRITEDATA[CFG_FMT_BIT];
				ack_mode_next  = I_AVS_WRITEDATA[CFG_ACK_BIT];
				len_next       = I_AVS_WRITEDATA[CFG_LEN_LSB +: 9];
			end else if (I_AVS_ADDRESS == REG_STAT && I_AVS_WRITEDATA[STAT_ERR_BIT]) begin
				err_next = 1'b0;
			end
		end
		if (err_set) begin
			err_next = 1'b1;
		end
	end
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			fmt_entry_reg <= 1'b0;
			ack_mode_reg  <= 1'b0;
			len_reg       <= CFG_LEN_RST;
			err_reg       <= 1'b0;
			idx_reg       <= 9'h000;
			ctl_prev_reg  <= 5'h00;
			ne_prev_reg   <= 1'b0;
			frag_num_reg  <= 8'h00;
			frag_rem_reg  <= 8'h00;
			frag_size_reg <= 8'h00;
			flags_reg     <= 2'h0;
			entry_len_reg <= 16'h0000;
			entry_cnt_reg <= 8'h00;
			gate_reg      <= 1'b0;
			stby_reg      <= 1'b0;
			ack_reg       <= 1'b0;
			drst_reg      <= 1'b0;
			eack_reg      <= 1'b0;
			newe_reg      <= 1'b0;
			done_reg      <= 1'b0;
			ev_reg        <= 1'b0;
			ed_reg        <= 8'h00;
			ei_reg        <= 8'h00;
			wait_reg      <= 1'b1;
			rdata_reg     <= 32'h0000_0000;
		end else if (I_CE) begin
			fmt_entry_reg <= fmt_entry_next;
			ack_mode_reg  <= ack_mode_next;
			len_reg       <= len_next;
			err_reg       <= err_next;
			idx_reg       <= idx_next;
			ctl_prev_reg  <= ctl_prev_next;
			ne_prev_reg   <= ne_prev_next;
			frag_num_reg  <= frag_num_next;
			frag_rem_reg  <= frag_rem_next;
			frag_size_reg <= frag_size_next;
			flags_reg     <= flags_next;
			entry_len_reg <= entry_len_next;
			entry_cnt_reg <= entry_cnt_next;
			gate_reg      <= gate_next;
			stby_reg      <= stby_next;
			ack_reg       <= ack_next;
			drst_reg      <= drst_next;
			eack_reg      <= eack_next;
			newe_reg      <= newe_next;
			done_reg      <= done_next;
			ev_reg        <= ev_next;
			ed_reg        <= ed_next;
			ei_reg        <= ei_next;
			wait_reg      <= wait_next;
			rdata_reg     <= rdata_next;
		end
	end
	assign O_AVS_READDATA    = rdata_reg;
	assign O_AVS_WAITREQUEST = wait_reg;
	assign O_GATE_OPEN       = gate_reg;
	assign O_STANDBY         = stby_reg;
	assign O_ACK_PULSE       = ack_reg;
	assign O_DATA_RESET      = drst_reg;
	assign O_ERROR_ACK       = eack_reg;
	assign O_NEW_ENTRY       = newe_reg;
	assign O_FRAME_DONE      = done_reg;
	assign O_ENTRY_VALID     = ev_reg;
	assign O_ENTRY_DATA      = ed_reg;
	assign O_ENTRY_INDEX     = ei_reg;
	// Checks
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	property p_gate_open;
		ctl_take && I_RX_DATA[CTL_ACT] && !ctl_prev_reg[CTL_ACT] |=> O_GATE_OPEN;
	endproperty
	a_gate_open: assert property (p_gate_open) else $error("gate not opened");
	property p_gate_close;
		ctl_take && !I_RX_DATA[CTL_ACT] && ctl_prev_reg[CTL_ACT] |=> !O_GATE_OPEN;
	endproperty
	a_gate_close: assert property (p_gate_close) else $error("gate not closed");
	property p_steady;
		ctl_take && (I_RX_DATA[CTL_ACT] == ctl_prev_reg[CTL_ACT]) |=> $stable(O_GATE_OPEN);
	endproperty
	a_steady: assert property (p_steady) else $error("gate moved on level");
	property p_ack_mode;
		O_ACK_PULSE |-> $past(ack_mode_reg) && $past(ctl_take);
	endproperty
	a_ack_mode: assert property (p_ack_mode) else $error("ack outside handshake");
	property p_data_reset;
		O_DATA_RESET |-> (entry_len_reg == 16'h0000) && (frag_num_reg == 8'h00);
	endproperty
	a_data_reset: assert property (p_data_reset) else $error("data not cleared");
	property p_absent;
		take && !in_len |=> !O_ENTRY_VALID && $stable(entry_len_reg);
	endproperty
	a_absent: assert property (p_absent) else $error("byte beyond length used");
	property p_full_data;
		take && in_len && !fmt_entry_reg && idx_reg == 9'h007
			|=> O_ENTRY_VALID && O_ENTRY_INDEX == 8'h00;
	endproperty
	a_full_data: assert property (p_full_data) else $error("full data start wrong");
	property p_entry_data;
		take && in_len && fmt_entry_reg && idx_reg == 9'h006
			|=> O_ENTRY_VALID && O_ENTRY_INDEX == 8'h00;
	endproperty
	a_entry_data: assert property (p_entry_data) else $error("entry data start wrong");
	property p_len_ok;
		take && I_RX_LAST && !err_reg && (len_reg != 9'h000) && (idx_reg == len_reg - 9'h001)
			&& (len_reg <= (fmt_entry_reg ? ENTRY_MAX_LEN : FULL_MAX_LEN)) |=> !err_reg;
	endproperty
	a_len_ok: assert property (p_len_ok) else $error("valid length refused");
endmodule : coap_parser

/* File: hw/coap_pkg.sv */
// Constants for the cyclic output assembly parser
package coap_pkg;
	// Assembly formats
	localparam logic [7:0] FMT_FULL_ID   = 8'h79;
	localparam logic [7:0] FMT_ENTRY_ID  = 8'h7A;
	localparam logic [8:0] FULL_MAX_LEN  = 9'h106;
	localparam logic [8:0] ENTRY_MAX_LEN = 9'h105;
	// Field positions in full-control byte numbering
	localparam logic [8:0] POS_CTRL      = 9'h000;
	localparam logic [8:0] POS_FRAG_NUM  = 9'h001;
	localparam logic [8:0] POS_FRAG_REM  = 9'h002;
	localparam logic [8:0] POS_FRAG_SIZE = 9'h003;
	localparam logic [8:0] POS_FLAGS     = 9'h004;
	localparam logic [8:0] POS_LEN_LO    = 9'h005;
	localparam logic [8:0] POS_LEN_HI    = 9'h006;
	localparam logic [8:0] POS_DATA      = 9'h007;
	// Control byte bits
	localparam int CTL_ACT   = 0;
	localparam int CTL_ACK   = 1;
	localparam int CTL_RST   = 2;
	localparam int CTL_EACK  = 3;
	localparam int CTL_STBY  = 4;
	// Flag byte bits
	localparam int FLG_NEW_DATA  = 0;
	localparam int FLG_NEW_ENTRY = 1;
	// Register byte offsets
	localparam logic [3:0] REG_CFG   = 4'h0;
	localparam logic [3:0] REG_STAT  = 4'h4;
	localparam logic [3:0] REG_FRAG  = 4'h8;
	localparam logic [3:0] REG_ENTRY = 4'hC;
	// Configuration fields and reset values
	localparam int CFG_FMT_BIT = 0;
	localparam int CFG_ACK_BIT = 1;
	localparam int CFG_LEN_LSB = 8;
	localparam logic [8:0] CFG_LEN_RST = 9'h007;
	localparam int STAT_ERR_BIT = 2;
endpackage : coap_pkg

/* File: tb/coap_plc_model.sv */
// Controller model that sends cyclic output assemblies byte by byte
`timescale 1ns/1ps
module coap_plc_model (
	// Clock, reset
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	// Frame request
	input  wire logic       i_start,
	input  wire logic       i_fmt,
	input  wire logic       i_slow,
	input  wire logic [8:0] i_len,
	input  wire logic [7:0] i_ctrl,
	input  wire logic [1:0] i_flags,
	input  wire logic [7:0] i_seed,
	// Byte stream
	output logic            o_valid,
	output logic [7:0]      o_data,
	output logic            o_last,
	output logic            o_busy
);
	logic [8:0] pos;
	logic       tick;
	function automatic logic [7:0] byte_at(input logic [8:0] q);
		logic [15:0] n;
		n = {7'h00, i_len} - (i_fmt ? 16'h0006 : 16'h0007);
		case (q)
			9'h000: byte_at = i_ctrl;
			9'h001: byte_at = i_seed;
			9'h002: byte_at = i_seed + 8'h01;
			9'h003: byte_at = i_seed + 8'h02;
			9'h004: byte_at = {6'h00, i_flags};
			9'h005: byte_at = n[7:0];
			9'h006: byte_at = n[15:8];
			default: byte_at = i_seed ^ q[7:0] - 8'h07;
		endcase
	endfunction : byte_at
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
			o_data  <= 8'h00;
			o_last  <= 1'b0;
			o_busy  <= 1'b0;
			pos     <= 9'h000;
			tick    <= 1'b0;
		end else if (o_busy && (tick || !i_slow)) begin
			tick    <= ~tick;
			o_valid <= 1'b1;
			o_data  <= byte_at(pos + {8'h00, i_fmt});
			o_last  <= (pos == i_len - 9'h001);
			pos     <= pos + 9'h001;
			o_busy  <= (pos != i_len - 9'h001);
		end else begin
			tick    <= ~tick;
			o_valid <= 1'b0;
			o_last  <= 1'b0;
			o_data  <= ~o_data;
			if (!o_busy && i_start) begin
				o_busy <= 1'b1;
				pos    <= 9'h000;
			end
		end
	end
endmodule : coap_plc_model

/* File: tb/tb.sv */
// Self-checking testbench for the assembly parser
`timescale 1ns/1ps
module tb;
	import coap_pkg::*;
	logic        I_CLOCK, I_RST_N, I_AVS_READ, I_AVS_WRITE, rv, rl, wq, ev, st, fm, slow, bsy;
	logic        gate, stby, ackp, drst, eack, nent, fdone, ce;
	logic [3:0]  I_AVS_ADDRESS;
	logic [7:0]  rd, ed, ei, ctrl, sd, s0;
	logic [1:0]  flg, pflg;
	logic [8:0]  len;
	logic [31:0] I_AVS_WRITEDATA, rdat, q;
	int          err_total, n_compared, seed, ent, c_ack, c_rst, c_eack, c_ne, c_fd, n, k, ne;
	coap_parser DUT (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_CE(ce),
		.I_RX_VALID(rv), .I_RX_DATA(rd), .I_RX_LAST(rl),
		.I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
		.I_AVS_WRITEDATA(I_AVS_WRITEDATA), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq),
		.O_GATE_OPEN(gate), .O_STANDBY(stby), .O_ACK_PULSE(ackp), .O_DATA_RESET(drst),
		.O_ERROR_ACK(eack), .O_NEW_ENTRY(nent), .O_FRAME_DONE(fdone),
		.O_ENTRY_VALID(ev), .O_ENTRY_DATA(ed), .O_ENTRY_INDEX(ei));
	coap_plc_model plc (.i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_start(st), .i_fmt(fm),
		.i_slow(slow), .i_len(len), .i_ctrl(ctrl), .i_flags(flg), .i_seed(sd),
		.o_valid(rv), .o_data(rd), .o_last(rl), .o_busy(bsy));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task av(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge I_CLOCK);
		I_AVS_READ      <= !w;
		I_AVS_WRITE     <= w;
		I_AVS_ADDRESS   <= a;
		I_AVS_WRITEDATA <= d;
		@(posedge I_CLOCK);
		while (wq !== 1'b0) @(posedge I_CLOCK);
		q = rdat;
		I_AVS_READ  <= 1'b0;
		I_AVS_WRITE <= 1'b0;
	endtask : av
	task cfg(input logic f, input logic a, input logic [8:0] l);
		av(1'b1, REG_CFG, ({23'h0, l} << CFG_LEN_LSB) | {30'h0, a, f});
	endtask : cfg
	task send(input logic f, input logic [8:0] l, input logic [7:0] c);
		@(posedge I_CLOCK);
		fm   <= f;
		len  <= l;
		ctrl <= c;
		st   <= 1'b1;
		ent = 0;
		@(posedge I_CLOCK);
		st <= 1'b0;
		@(posedge I_CLOCK);
		while (bsy !== 1'b0) @(posedge I_CLOCK);
		repeat (3) @(posedge I_CLOCK);
	endtask : send
	function automatic logic [31:0] fragx(input logic [7:0] s, input logic [1:0] f);
		fragx = {6'h00, f, s + 8'h02, s + 8'h01, s};
	endfunction : fragx
	task wrap_up;
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	always @(posedge I_CLOCK) begin
		if (ev === 1'b1) begin
			chk({24'h0, ed}, {24'h0, sd ^ ent[7:0]});
			chk({24'h0, ei}, ent);
			ent++;
		end
		c_ack  += (ackp === 1'b1);
		c_rst  += (drst === 1'b1);
		c_eack += (eack === 1'b1);
		c_ne   += (nent === 1'b1);
		c_fd   += (fdone === 1'b1);
	end
	initial begin
		I_CLOCK = 1'b0;
		forever #50 I_CLOCK = ~I_CLOCK;
	end
	initial begin
		repeat (40000) @(posedge I_CLOCK);
		err_total++;
		wrap_up();
	end
	initial begin
		{I_RST_N, I_AVS_READ, I_AVS_WRITE, st, fm, slow, ce} = 7'h01;
		{I_AVS_ADDRESS, I_AVS_WRITEDATA, ctrl, sd, flg, len} = 0;
		{err_total, n_compared, ent, c_ack, c_rst, c_eack, c_ne, c_fd, ne} = 0;
		seed = 72147;
		pflg = 2'h0;
		repeat (20) @(posedge I_CLOCK);
		I_RST_N <= 1'b1;
		av(1'b0, REG_CFG, 0);
		chk(q, {23'h0, CFG_LEN_RST} << CFG_LEN_LSB);
		av(1'b0, 4'h2, 0);
		chk(q, 0);
		for (k = 0; k < 8; k++) begin
			fm = (k < 2) ? k[0] : $random(seed);
			n = (k < 2) ? 255 : {$random(seed)} % 21;
			sd = $random(seed);
			flg = $random(seed);
			slow = k[0];
			cfg(fm, 1'b0, n + (fm ? 6 : 7));
			send(fm, n + (fm ? 6 : 7), 8'h00);
			chk(ent, n);
			av(1'b0, REG_FRAG, 0);
			chk(q, fragx(sd, flg));
			av(1'b0, REG_ENTRY, 0);
			chk(q, n);
			av(1'b0, REG_STAT, 0);
			chk(q[STAT_ERR_BIT], 1'b0);
			ne += (flg[1] != pflg[1]);
			pflg = flg;
		end
		chk(c_fd, 8);
		chk(c_ne, ne);
		s0 = sd;
		sd = 8'hA5;
		cfg(1'b0, 1'b0, 9'h003);
		send(1'b0, 9'h003, 8'h00);
		av(1'b0, REG_FRAG, 0);
		chk(q, {6'h00, flg, s0 + 8'h02, sd + 8'h01, sd});
		av(1'b0, REG_ENTRY, 0);
		chk(q, n);
		cfg(1'b0, 1'b0, 9'h001);
		send(1'b0, 9'h001, 8'h01);
		chk(gate, 1'b1);
		send(1'b0, 9'h001, 8'h01);
		chk(c_eack, 0);
		send(1'b0, 9'h001, 8'h19);
		chk({stby, gate, c_eack[1:0]}, 4'hD);
		send(1'b0, 9'h001, 8'h00);
		chk({stby, gate}, 2'h0);
		send(1'b0, 9'h001, 8'h02);
		send(1'b0, 9'h001, 8'h00);
		chk(c_ack, 0);
		cfg(1'b0, 1'b1, 9'h001);
		send(1'b0, 9'h001, 8'h02);
		send(1'b0, 9'h001, 8'h00);
		chk(c_ack, 2);
		send(1'b0, 9'h001, 8'h04);
		chk(c_rst, 1);
		av(1'b0, REG_FRAG, 0);
		chk(q, 0);
		av(1'b0, REG_ENTRY, 0);
		chk(q, 0);
		ce <= 1'b0;
		send(1'b0, 9'h001, 8'h01);
		ce <= 1'b1;
		chk(gate, 1'b0);
		send(1'b0, 9'h001, 8'h01);
		chk(gate, 1'b1);
		cfg(1'b0, 1'b0, 9'h107);
		send(1'b0, 9'h107, 8'h00);
		av(1'b0, REG_STAT, 0);
		chk(q[STAT_ERR_BIT], 1'b1);
		av(1'b1, REG_STAT, 32'h4);
		av(1'b0, REG_STAT, 0);
		chk(q[STAT_ERR_BIT], 1'b0);
		cfg(1'b1, 1'b0, 9'h106);
		send(1'b1, 9'h106, 8'h00);
		av(1'b0, REG_STAT, 0);
		chk(q[STAT_ERR_BIT], 1'b1);
		wrap_up();
	end
endmodule : tb
